// >>> inc/ctt_pkg.sv
// package: constants and carriers for the charger throttle and current registers
`default_nettype none
package ctt_pkg;
   // ----------------------------------------------------------------
   // clock
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_THROT1_LO = 8'h06;
   localparam logic [7:0] OFS_THROT1_HI = 8'h07;
   localparam logic [7:0] OFS_CC_LO     = 8'h0A;
   localparam logic [7:0] OFS_CC_HI     = 8'h0B;
   localparam logic [7:0] OFS_CC_WORD   = 8'h14;
   localparam logic [7:0] OFS_THROT1    = 8'h3D;

   // ----------------------------------------------------------------
   // throttle_option1 fields
   // ----------------------------------------------------------------
   localparam int THR_LSB   = 10;
   localparam int THR_W     = 6;
   localparam int DEGL_LSB  = 8;
   localparam int RSVD_BIT  = 7;
   localparam int MASK_W    = 7;
   localparam int M_INDEP   = 6;
   localparam int M_CRIT    = 5;
   localparam int M_NOM     = 4;
   localparam int M_DCHG    = 3;
   localparam int M_SYSV    = 2;
   localparam int M_BATTERY_PRESENCE = 1;
   localparam int M_ADPGOOD = 0;
   localparam logic [15:0] THROT1_RST = 16'h8124;
   // sources kept in force with the adapter removed
   localparam logic [6:0] MASK_NO_ADAPTER = 7'h4C;
   localparam int THR_STEP_SHIFT = 9;

   // ----------------------------------------------------------------
   // charge current fields
   // ----------------------------------------------------------------
   localparam int CC_LSB   = 6;
   localparam int CC_W     = 7;
   localparam int CC_BAD_LSB = 13;
   localparam logic [15:0] CC_RST = 16'h0000;
   localparam int CC_STEP_MA   = 64;
   localparam int CLAMP_LOW_MA = 384;
   localparam int CLAMP_MID_MA = 2000;
   localparam logic [6:0] CODE_LOW = 7'(CLAMP_LOW_MA / CC_STEP_MA);
   localparam logic [6:0] CODE_MID = 7'(CLAMP_MID_MA / CC_STEP_MA);

   // ----------------------------------------------------------------
   // timing (ns, watchdog in ms, cycles derived)
   // ----------------------------------------------------------------
   localparam int T_100US_NS = 100_000;
   localparam int T_1MS_NS   = 1_000_000;
   localparam int T_1P6MS_NS = 1_600_000;
   localparam int T_6MS_NS   = 6_000_000;
   localparam int T_12MS_NS  = 12_000_000;
   localparam int WDT_MS     = 1000;
   localparam int CYC_100US  = T_100US_NS * CLK_MHZ / 1000;
   localparam int CYC_1MS    = T_1MS_NS * CLK_MHZ / 1000;
   localparam int CYC_1P6MS  = T_1P6MS_NS * CLK_MHZ / 1000;
   localparam int CYC_6MS    = T_6MS_NS * CLK_MHZ / 1000;
   localparam int CYC_12MS   = T_12MS_NS * CLK_MHZ / 1000;
   localparam int CYC_WDT    = WDT_MS * CLK_MHZ * 1000;
   localparam int TW         = 18;
   localparam int WDT_W      = 25;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } ctt_cmd_t;

   typedef struct packed {
      logic        adapter_present;
      logic        indep_comp_trip;
      logic        critical_input_current;
      logic        nominal_input_current;
      logic        system_voltage_low;
      logic        battery_presence;
      logic        adapter_good;
      logic [15:0] battery_current_monitor;
      logic        precharge;
      logic        single_cell;
      logic        below_battery_low_threshold;
      logic        below_minimum_system_level;
      logic        pulse_ext_en;
      logic        host_clear;
      logic [1:0]  pulse_width_sel;
   } ctt_mon_t;

   typedef enum logic [1:0] {
      HOT_IDLE  = 2'b00,
      HOT_HOLD  = 2'b01,
      HOT_LATCH = 2'b10
   } ctt_hot_t;
endpackage
`default_nettype wire

// >>> src/ctt_persist.sv
// persistence filter: output rises once the level has held for target cycles
`default_nettype none
module ctt_persist #(
   parameter int W = 18
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         level_i,
   input  wire logic [W-1:0] target_i,
   output var  logic         hit_o
);
   logic [W-1:0] count;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         count <= '0;
         hit_o <= 1'b0;
      end
      else if (!level_i)
      begin
         count <= '0;
         hit_o <= 1'b0;
      end
      else if (count + W'(1) >= target_i)
      begin
         hit_o <= 1'b1;
      end
      else
      begin
         count <= count + W'(1);
      end
   end

   // hit only while level stands
   a_persist_level : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hit_o |-> $past(level_i))
      else $error("persist output without level");
endmodule // ctt_persist
`default_nettype wire

// >>> src/ctt_regs.sv
// throttle option and charge current register bank with throttle output
`default_nettype none
module ctt_regs #(
   parameter int CYC_1MS   = ctt_pkg::CYC_1MS,
   parameter int CYC_1P6MS = ctt_pkg::CYC_1P6MS,
   parameter int CYC_6MS   = ctt_pkg::CYC_6MS,
   parameter int CYC_12MS  = ctt_pkg::CYC_12MS,
   parameter int CYC_WDT   = ctt_pkg::CYC_WDT
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire ctt_pkg::ctt_cmd_t cmd_i,
   input  wire ctt_pkg::ctt_mon_t mon_i,
   output var  logic [15:0]       rd_data_o,
   output var  logic              rd_valid_o,
   output var  logic              processor_hot_n_o,
   output var  logic              discharge_trip_o,
   output var  logic [6:0]        charge_current_code_o,
   output var  logic              charge_enable_o
);
   localparam int TW = ctt_pkg::TW;
   localparam int WW = ctt_pkg::WDT_W;

   logic [15:0]       throttle_option1;
   logic [15:0]       charge_current_setting;
   logic [7:0]        cc_low_pending;
   logic              pending;
   logic [WW-1:0]     wdt_count;
   logic              over_thr;
   logic              dchg_hit;
   logic              pres_q;
   logic              good_q;
   ctt_pkg::ctt_hot_t hot_state;
   ctt_pkg::ctt_hot_t next_hot_state;
   logic [TW-1:0]     hot_count;
   logic [TW-1:0]     next_hot_count;
   logic [6:0]        mask_eff;
   logic              level_src;
   logic              edge_src;
   logic [6:0]        next_code;
   logic [15:0]       next_rd;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_wr(input ctt_pkg::ctt_cmd_t c, input logic [7:0] a);
      return c.valid && c.write && (c.addr == a);
   endfunction

   function automatic logic cc_valid(input logic [15:0] v);
      return v[15:ctt_pkg::CC_BAD_LSB] == 3'h0;
   endfunction

   function automatic logic [TW-1:0] degl_cycles(input logic [1:0] sel);
      unique case (sel)
         2'h0: return TW'(CYC_1P6MS);
         2'h1: return TW'(ctt_pkg::CYC_100US);
         2'h2: return TW'(CYC_6MS);
         2'h3: return TW'(CYC_12MS);
      endcase
   endfunction

   function automatic logic [TW-1:0] pulse_cycles(input logic [1:0] sel);
      unique case (sel)
         2'h0: return TW'(ctt_pkg::CYC_100US);
         2'h1: return TW'(CYC_1MS);
         2'h2: return TW'(CYC_12MS);
         2'h3: return TW'(CYC_6MS);
      endcase
   endfunction

   // ----------------------------------------------------------------
   // throttle option register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         throttle_option1 <= ctt_pkg::THROT1_RST;
      end
      else if (is_wr(cmd_i, ctt_pkg::OFS_THROT1))
      begin
         throttle_option1 <= cmd_i.wdata & ~(16'h0001 << ctt_pkg::RSVD_BIT);
      end
      else if (is_wr(cmd_i, ctt_pkg::OFS_THROT1_LO))
      begin
         throttle_option1[7:0] <= {1'b0, cmd_i.wdata[6:0]};
      end
      else if (is_wr(cmd_i, ctt_pkg::OFS_THROT1_HI))
      begin
         throttle_option1[15:8] <= cmd_i.wdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // charge current register and two-byte sequence
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         charge_current_setting <= ctt_pkg::CC_RST;
      end
      // code kept in 64 mA steps
      else if (is_wr(cmd_i, ctt_pkg::OFS_CC_WORD) && cc_valid(cmd_i.wdata))
      begin
         charge_current_setting <= {cmd_i.wdata[15:6], 6'h00};
      end
      // update only when the pair completes
      else if (is_wr(cmd_i, ctt_pkg::OFS_CC_HI) && pending
               && cc_valid({cmd_i.wdata[7:0], cc_low_pending}))
      begin
         charge_current_setting <= {cmd_i.wdata[7:0], cc_low_pending[7:6], 6'h00};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pending        <= 1'b0;
         cc_low_pending <= 8'h00;
      end
      else if (is_wr(cmd_i, ctt_pkg::OFS_CC_LO))
      begin
         pending        <= 1'b1;
         cc_low_pending <= cmd_i.wdata[7:0];
      end
      else if (pending && (wdt_count >= WW'(CYC_WDT - 1)))
      begin
         pending <= 1'b0;
      end
      // any other command ends the pair
      else if (cmd_i.valid)
      begin
         pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !pending || is_wr(cmd_i, ctt_pkg::OFS_CC_LO))
      begin
         wdt_count <= '0;
      end
      else
      begin
         wdt_count <= wdt_count + WW'(1);
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (cmd_i.addr)
         ctt_pkg::OFS_THROT1:    next_rd = throttle_option1;
         ctt_pkg::OFS_THROT1_LO: next_rd = {8'h00, throttle_option1[7:0]};
         ctt_pkg::OFS_THROT1_HI: next_rd = {8'h00, throttle_option1[15:8]};
         ctt_pkg::OFS_CC_WORD:   next_rd = charge_current_setting;
         ctt_pkg::OFS_CC_LO:     next_rd = {8'h00, charge_current_setting[7:0]};
         ctt_pkg::OFS_CC_HI:     next_rd = {8'h00, charge_current_setting[15:8]};
         default:                next_rd = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_o  <= 16'h0000;
         rd_valid_o <= 1'b0;
      end
      else
      begin
         rd_valid_o <= cmd_i.valid && !cmd_i.write;
         if (cmd_i.valid && !cmd_i.write)
         begin
            rd_data_o <= next_rd;
         end
      end
   end

   // ----------------------------------------------------------------
   // discharge comparator
   // ----------------------------------------------------------------
   // threshold in 512 mA steps
   assign over_thr = mon_i.battery_current_monitor >
      16'({throttle_option1[ctt_pkg::THR_LSB +: ctt_pkg::THR_W], 9'h000});

   ctt_persist #(
      .W (TW)
   ) u_dchg_persist (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .level_i  (over_thr),
      .target_i (degl_cycles(throttle_option1[ctt_pkg::DEGL_LSB +: 2])),
      .hit_o    (dchg_hit)
   );

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         discharge_trip_o <= 1'b0;
      end
      else
      begin
         discharge_trip_o <= dchg_hit;
      end
   end

   // ----------------------------------------------------------------
   // throttle sources
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pres_q <= 1'b0;
         good_q <= 1'b1;
      end
      else
      begin
         pres_q <= mon_i.battery_presence;
         good_q <= mon_i.adapter_good;
      end
   end

   // adapter removal keeps only three sources
   assign mask_eff = throttle_option1[ctt_pkg::MASK_W-1:0]
                   & (mon_i.adapter_present ? 7'h7F : ctt_pkg::MASK_NO_ADAPTER);

   assign level_src = (mask_eff[ctt_pkg::M_INDEP] && mon_i.indep_comp_trip)
                    | (mask_eff[ctt_pkg::M_CRIT]  && mon_i.critical_input_current)
                    | (mask_eff[ctt_pkg::M_NOM]   && mon_i.nominal_input_current)
                    | (mask_eff[ctt_pkg::M_DCHG]  && dchg_hit)
                    | (mask_eff[ctt_pkg::M_SYSV]  && mon_i.system_voltage_low);

   assign edge_src = (mask_eff[ctt_pkg::M_BATTERY_PRESENCE] && mon_i.battery_presence && !pres_q)
                   | (mask_eff[ctt_pkg::M_ADPGOOD] && !mon_i.adapter_good && good_q);

   // ----------------------------------------------------------------
   // throttle output state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_hot_state = hot_state;
      next_hot_count = (hot_count != '0) ? hot_count - TW'(1) : hot_count;
      unique case (hot_state)
         ctt_pkg::HOT_IDLE:
         begin
            if (level_src || edge_src)
            begin
               next_hot_state = mon_i.pulse_ext_en ? ctt_pkg::HOT_LATCH
                                                   : ctt_pkg::HOT_HOLD;
               next_hot_count = pulse_cycles(mon_i.pulse_width_sel) - TW'(1);
            end
         end
         ctt_pkg::HOT_HOLD:
         begin
            if (mon_i.pulse_ext_en)
            begin
               next_hot_state = ctt_pkg::HOT_LATCH;
            end
            else if (hot_count == '0 && !level_src && !edge_src)
            begin
               next_hot_state = ctt_pkg::HOT_IDLE;
            end
         end
         ctt_pkg::HOT_LATCH:
         begin
            if (mon_i.host_clear)
            begin
               next_hot_state = ctt_pkg::HOT_IDLE;
            end
         end
         default:
         begin
            next_hot_state = ctt_pkg::HOT_IDLE;
         end
      endcase
   end

   // hold low for width or until cleared
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         hot_state         <= ctt_pkg::HOT_IDLE;
         hot_count         <= '0;
         processor_hot_n_o <= 1'b1;
      end
      else
      begin
         hot_state         <= next_hot_state;
         hot_count         <= next_hot_count;
         processor_hot_n_o <= (next_hot_state == ctt_pkg::HOT_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // effective charge current
   // ----------------------------------------------------------------
   always_comb
   begin
      next_code = charge_current_setting[ctt_pkg::CC_LSB +: ctt_pkg::CC_W];
      if (mon_i.precharge && next_code > ctt_pkg::CODE_LOW)
      begin
         next_code = ctt_pkg::CODE_LOW;
      end
      // single cell clamps by battery level
      if (mon_i.single_cell && mon_i.below_battery_low_threshold
          && next_code > ctt_pkg::CODE_LOW)
      begin
         next_code = ctt_pkg::CODE_LOW;
      end
      else if (mon_i.single_cell && mon_i.below_minimum_system_level
               && next_code > ctt_pkg::CODE_MID)
      begin
         next_code = ctt_pkg::CODE_MID;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         charge_current_code_o <= 7'h00;
         charge_enable_o       <= 1'b0;
      end
      else
      begin
         charge_current_code_o <= next_code;
         charge_enable_o       <= (charge_current_setting != 16'h0000);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_rsvd_bit_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      throttle_option1[ctt_pkg::RSVD_BIT] == 1'b0)
      else $error("reserved option bit set");

   a_cc_low_ignored : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      charge_current_setting[5:0] == 6'h00)
      else $error("ignored charge bits stored");

   a_cc_invalid_keep : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      is_wr(cmd_i, ctt_pkg::OFS_CC_WORD) && !cc_valid(cmd_i.wdata)
      |=> $stable(charge_current_setting))
      else $error("invalid charge write changed setting");

   a_orphan_high : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      is_wr(cmd_i, ctt_pkg::OFS_CC_HI) && !pending
      |=> $stable(charge_current_setting))
      else $error("orphan high byte updated setting");

   a_pair_update : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      is_wr(cmd_i, ctt_pkg::OFS_CC_HI) && pending && cmd_i.wdata[7:5] == 3'h0
      |=> charge_current_setting[15:6] == {$past(cmd_i.wdata[7:0]), $past(cc_low_pending[7:6])})
      else $error("byte pair not applied");

   a_mask_zero_quiet : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      throttle_option1[6:0] == 7'h00 && processor_hot_n_o |=> processor_hot_n_o)
      else $error("throttle asserted with empty mask");

   a_precharge_clamp : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(mon_i.precharge) |-> charge_current_code_o <= ctt_pkg::CODE_LOW)
      else $error("pre-charge current not clamped");

   a_zero_disables : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      charge_current_setting == 16'h0000 |=> !charge_enable_o)
      else $error("charging with zero setting");

   a_latch_holds : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hot_state == ctt_pkg::HOT_LATCH && !mon_i.host_clear |=> !processor_hot_n_o)
      else $error("extended throttle released early");
endmodule // ctt_regs
`default_nettype wire

// >>> verification/ctt_host.sv
// host controller model driving the register command port
`default_nettype none
module ctt_host (
   input  wire logic              clk_i,
   input  wire logic [15:0]       rd_data_i,
   input  wire logic              rd_valid_i,
   output var  ctt_pkg::ctt_cmd_t cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial cmd_o = '0;

   // ----------------------------------------------------------------
   // command strobes
   // ----------------------------------------------------------------
   // one command per strobe, fields scrambled once released
   task automatic send(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      #1;
      cmd_o = '{1'b1, w, a, d};
      @(posedge clk_i);
      #1;
      cmd_o = '{1'b0, ~w, ~a, ~d};
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      send(1'b1, a, d);
   endtask

   // answer sampled one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      send(1'b0, a, 16'h0000);
      d = rd_valid_i ? rd_data_i : 16'hF0F0;
   endtask
endmodule // ctt_host
`default_nettype wire

// >>> verification/ctt_regs_tb_top.sv
// testbench for the throttle and charge current register bank
`default_nettype none
module ctt_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk_i;
   logic              rst_n_i;
   ctt_pkg::ctt_cmd_t cmd;
   ctt_pkg::ctt_mon_t mon;
   logic [15:0]       rd_data;
   logic              rd_valid;
   logic              hot_n;
   logic              trip;
   logic [6:0]        code;
   logic              chg_en;
   logic [15:0]       v;
   int                n_errors = 0;
   int                samples_checked = 0;

   ctt_regs #(
      .CYC_1MS(20), .CYC_1P6MS(32), .CYC_6MS(60), .CYC_12MS(120), .CYC_WDT(200)
   ) i_dut (
      .clk_i                 (clk_i),
      .rst_n_i               (rst_n_i),
      .cmd_i                 (cmd),
      .mon_i                 (mon),
      .rd_data_o             (rd_data),
      .rd_valid_o            (rd_valid),
      .processor_hot_n_o     (hot_n),
      .discharge_trip_o      (trip),
      .charge_current_code_o (code),
      .charge_enable_o       (chg_en)
   );

   ctt_host i_host (
      .clk_i      (clk_i),
      .rd_data_i  (rd_data),
      .rd_valid_i (rd_valid),
      .cmd_o      (cmd)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic rdchk(input string s, input logic [7:0] a, input logic [15:0] e);
      i_host.rd(a, v);
      chk(s, e, v);
   endtask

   task automatic end_sim;
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rdchk("opt1", ctt_pkg::OFS_THROT1, ctt_pkg::THROT1_RST);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h0000);
      chk("hot_n", 16'h0001, {15'h0000, hot_n});
   endtask

   task automatic t_word;
      i_host.wr(ctt_pkg::OFS_CC_WORD, 16'h01FF);
      cyc(3);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h01C0);
      chk("code", 16'h0007, {9'h000, code});
      chk("en", 16'h0001, {15'h0000, chg_en});
      i_host.wr(ctt_pkg::OFS_CC_WORD, 16'h2000);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h01C0);
      i_host.wr(ctt_pkg::OFS_CC_WORD, 16'h0000);
      cyc(3);
      chk("en", 16'h0000, {15'h0000, chg_en});
   endtask

   task automatic t_pair;
      i_host.wr(ctt_pkg::OFS_CC_LO, 16'h00C0);
      i_host.wr(ctt_pkg::OFS_CC_HI, 16'h0001);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h01C0);
      i_host.wr(ctt_pkg::OFS_CC_HI, 16'h0002);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h01C0);
      i_host.wr(ctt_pkg::OFS_CC_LO, 16'h0040);
      i_host.rd(ctt_pkg::OFS_THROT1, v);
      i_host.wr(ctt_pkg::OFS_CC_HI, 16'h0003);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h01C0);
      i_host.wr(ctt_pkg::OFS_CC_LO, 16'h0040);
      cyc(210);
      i_host.wr(ctt_pkg::OFS_CC_HI, 16'h0003);
      rdchk("cc", ctt_pkg::OFS_CC_WORD, 16'h01C0);
   endtask

   task automatic t_trip;
      i_host.wr(ctt_pkg::OFS_THROT1, 16'hFFFF);
      rdchk("opt1", ctt_pkg::OFS_THROT1, 16'hFF7F);
      mon.battery_current_monitor = 16'h0200;
      i_host.wr(ctt_pkg::OFS_THROT1, 16'h0400);
      cyc(40);
      chk("trip", 16'h0000, {15'h0000, trip});
      mon.battery_current_monitor = 16'h0201;
      cyc(20);
      chk("trip", 16'h0000, {15'h0000, trip});
      cyc(20);
      chk("trip", 16'h0001, {15'h0000, trip});
      mon.battery_current_monitor = 16'h0000;
   endtask

   task automatic hot(input logic [15:0] opt, input logic e);
      i_host.wr(ctt_pkg::OFS_THROT1, opt);
      cyc(4);
      chk("hot_n", {15'h0000, e}, {15'h0000, hot_n});
   endtask

   task automatic unlatch;
      mon.host_clear = 1'b1;
      cyc(3);
      chk("hot_n", 16'h0001, {15'h0000, hot_n});
      mon.host_clear = 1'b0;
   endtask

   task automatic t_hot;
      mon.pulse_ext_en = 1'b1;
      mon.adapter_present = 1'b1;
      mon.critical_input_current = 1'b1;
      mon.system_voltage_low = 1'b1;
      hot(16'h8100, 1'b1);
      mon.adapter_present = 1'b0;
      hot(16'h8120, 1'b1);
      mon.adapter_present = 1'b1;
      cyc(3);
      chk("hot_n", 16'h0000, {15'h0000, hot_n});
      mon.critical_input_current = 1'b0;
      cyc(5);
      chk("hot_n", 16'h0000, {15'h0000, hot_n});
      unlatch();
      mon.adapter_present = 1'b0;
      hot(16'h8104, 1'b0);
      mon.system_voltage_low = 1'b0;
      unlatch();
      mon.adapter_present = 1'b1;
      hot(16'h8102, 1'b1);
      mon.battery_presence = 1'b1;
      cyc(3);
      chk("hot_n", 16'h0000, {15'h0000, hot_n});
      unlatch();
      hot(16'h8101, 1'b1);
      mon.adapter_good = 1'b0;
      cyc(3);
      chk("hot_n", 16'h0000, {15'h0000, hot_n});
      unlatch();
      // minimum pulse width without extension, 1 ms selected
      mon.pulse_ext_en = 1'b0;
      mon.pulse_width_sel = 2'b01;
      mon.adapter_good = 1'b1;
      cyc(2);
      mon.adapter_good = 1'b0;
      cyc(15);
      chk("hot_n", 16'h0000, {15'h0000, hot_n});
      cyc(10);
      chk("hot_n", 16'h0001, {15'h0000, hot_n});
   endtask

   task automatic t_clamp;
      i_host.wr(ctt_pkg::OFS_CC_WORD, 16'h1000);
      mon.precharge = 1'b1;
      cyc(3);
      chk("code", 16'h0006, {9'h000, code});
      mon.precharge = 1'b0;
      mon.single_cell = 1'b1;
      mon.below_minimum_system_level = 1'b1;
      cyc(3);
      chk("code", 16'h001F, {9'h000, code});
      mon.below_battery_low_threshold = 1'b1;
      cyc(3);
      chk("code", 16'h0006, {9'h000, code});
      mon.below_battery_low_threshold = 1'b0;
      mon.below_minimum_system_level = 1'b0;
      cyc(3);
      chk("code", 16'h0040, {9'h000, code});
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      rst_n_i = 1'b0;
      mon = '0;
      mon.adapter_good = 1'b1;
      repeat (12) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      t_reset();
      t_word();
      t_pair();
      t_trip();
      t_hot();
      t_clamp();
      end_sim();
   end

   initial
   begin
      #1_000_000;
      n_errors++;
      end_sim();
   end
endmodule // ctt_regs_tb_top
`default_nettype wire
